/* core/fpsi_pkg.sv */
// Shared constants of the flow pulse and status indicator block.
// Assumes a single 200 MHz clock and a 32-bit APB register bus.
package fpsi_pkg;
  // Clock and flash timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int FLASH_HALF_NS = 250_000_000;
  localparam int FLASH_HALF_CYC = FLASH_HALF_NS / CLK_PERIOD_NS;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_INT_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h0C;

  // Event bits, shared by status, sticky status and mask
  localparam int EV_PICKUP = 0;
  localparam int EV_INTERP = 1;
  localparam int EV_OVERLOAD = 2;
  localparam int EV_ELEC = 3;
  localparam int EV_CONFIG = 4;
  localparam int EV_W = 5;
  localparam logic [EV_W-1:0] INT_MASK_RST = 5'h00;

  // State register fields
  localparam int ST_RED = 0;
  localparam int ST_GREEN = 1;
  localparam int ST_YELLOW = 2;
  localparam int ST_CODE_LSB = 4;
  localparam int ST_PHASE_LSB = 8;
  localparam int ST_DIR = 10;
  localparam int ST_MODE_LSB = 12;

  // Factor selection
  localparam logic [3:0] FIRST_BAD_CODE = 4'hB;
  localparam int FACTOR_W = 6;
  localparam logic [FACTOR_W-1:0] ACC_MODULUS = 6'h20;
  localparam logic [FACTOR_W-1:0] FACTOR_TAB [0:10] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h08,
                                                       6'h0A, 6'h0C, 6'h10, 6'h18, 6'h20};

  // Operating mode, highest priority has the highest code
  typedef enum logic [1:0] {
    FPSI_RUN = 2'b00,
    FPSI_NOFACTOR = 2'b01,
    FPSI_CONFIG = 2'b10,
    FPSI_FATAL = 2'b11
  } fpsi_mode_t;
endpackage

/* core/fpsi_flash.sv */
// Free-running flash timer: equal on and off halves of HALF cycles.
// Assumes the clock enable freezes it along with the rest of the block.
module fpsi_flash #(
  parameter int HALF = fpsi_pkg::FLASH_HALF_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Flash phase
  output logic lit
);
  import fpsi_pkg::*;

  localparam int CW = $clog2(HALF + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic lit;
  } fpsi_flash_st_t;

  fpsi_flash_st_t r, n;

  // Count one half period, then flip the phase
  always_comb begin
    n = r;
    if (r.cnt == CW'(HALF - 1)) begin
      n.cnt = '0;
      n.lit = ~r.lit;
    end else begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign lit = r.lit;
endmodule

/* core/fpsi_quad.sv */
// Fractional rate divider and quadrature phase counter.
// Each up step adds the factor, each down step subtracts it; every ACC_MODULUS moves the phase a quarter.
module fpsi_quad (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Motion input
  input wire logic en,
  input wire logic stepUp,
  input wire logic stepDown,
  input wire logic [fpsi_pkg::FACTOR_W-1:0] factor,
  // Phase output
  output logic [1:0] phase,
  output logic dirPos
);
  import fpsi_pkg::*;

  typedef struct packed {
    logic [FACTOR_W-1:0] acc;
    logic [1:0] phase;
    logic dirPos;
  } fpsi_quad_st_t;

  fpsi_quad_st_t r, n;
  logic [FACTOR_W-1:0] sum;

  // Advance or retreat one quarter period when the accumulator wraps
  always_comb begin
    n = r;
    sum = r.acc + factor;
    if (!en) begin
      n.acc = '0;
    end else if (stepUp && !stepDown) begin
      if (sum >= ACC_MODULUS) begin
        n.acc = sum - ACC_MODULUS;
        n.phase = r.phase + 2'h1;
        n.dirPos = 1'b1;
      end else begin
        n.acc = sum;
      end
    end else if (stepDown && !stepUp) begin
      if (r.acc >= factor) begin
        n.acc = r.acc - factor;
      end else begin
        n.acc = r.acc + ACC_MODULUS - factor;
        n.phase = r.phase - 2'h1;
        n.dirPos = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '{acc: '0, phase: 2'h0, dirPos: 1'b1};
    end else if (ce) begin
      r <= n;
    end
  end

  assign phase = r.phase;
  assign dirPos = r.dirPos;
endmodule

/* core/fpsi_indicator.sv */
// Top of the flow pulse and status indicator: lamps, quadrature pins, APB.
// Assumes all inputs synchronous to mclk and one APB master.
// Functional notes
// - Valid factor: green on; none: green flashes
// - Three fault events light the red lamp
// - Configuration needed: all lamps on, no pulses
// - Pickup or interpolator fault: red, pulses continue
// - Flow overload: red, other lamps unchanged
// - Electronics error: all flash, latched, no pulses
// - Two channels a quarter period apart
// - Direction pin high forward, low reverse
// - Reported direction invertible only by the reverse switch, which also swaps channels
// - Output-inhibiting error floats all three pins
// - Only eleven factors from one to 32
// - Codes 0-A map factors, B-F none, immediate
// - Reverse swaps channels and inverts direction pin
module fpsi_indicator #(
  parameter int FLASH_HALF = fpsi_pkg::FLASH_HALF_CYC
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fpsi_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Health inputs
  input wire logic magneticPickupFault,
  input wire logic interpFault,
  input wire logic flowOverload,
  input wire logic elecError,
  input wire logic configMissing,
  // Fine steps from the interpolator
  input wire logic stepUp,
  input wire logic stepDown,
  // Board switches
  input wire logic [3:0] factorSelectorSwitch,
  input wire logic directionReverseSwitch,
  // Output pins
  output logic chanAOut,
  output logic chanAOe,
  output logic chanBOut,
  output logic chanBOe,
  output logic directionOutput,
  output logic directionOutputOe,
  // Lamps
  output logic lampYellow,
  output logic lampGreen,
  output logic lampRed,
  // Interrupt
  output logic irq
);
  import fpsi_pkg::*;

  typedef struct packed {
    fpsi_mode_t mode;
    logic elecLatch;
    logic rev;
    logic [EV_W-1:0] prevEv;
    logic [EV_W-1:0] intStat;
    logic [EV_W-1:0] intMask;
    logic [2:0] lamps;
    logic chanA;
    logic chanB;
    logic dirOut;
    logic pinOe;
    logic [31:0] prdata;
    logic pslverr;
    logic rdReady;
  } fpsi_top_st_t;

  fpsi_top_st_t r, n;
  fpsi_mode_t modeNow;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] rise;
  logic [FACTOR_W-1:0] factor;
  logic validCode;
  logic fatal;
  logic redAlarm;
  logic flashLit;
  logic [1:0] qPhase;
  logic qDirPos;
  logic qA;
  logic qB;
  logic mapped;
  logic [31:0] rdMux;
  logic xferDone;

  // Flash timer
  fpsi_flash #(
    .HALF(FLASH_HALF)
  ) u_flash (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .lit(flashLit)
  );

  // Quadrature generator, runs only in normal operation
  fpsi_quad u_quad (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .en(modeNow == FPSI_RUN),
    .stepUp(stepUp),
    .stepDown(stepDown),
    .factor(factor),
    .phase(qPhase),
    .dirPos(qDirPos)
  );

  // Factor decode straight from the selector, no latching
  always_comb begin
    validCode = factorSelectorSwitch < FIRST_BAD_CODE;
    factor = validCode ? FACTOR_TAB[factorSelectorSwitch] : '0;
  end

  // Events and mode priority
  always_comb begin
    ev = '0;
    ev[EV_PICKUP] = magneticPickupFault;
    ev[EV_INTERP] = interpFault;
    ev[EV_OVERLOAD] = flowOverload;
    ev[EV_ELEC] = elecError;
    ev[EV_CONFIG] = configMissing;
    rise = ev & ~r.prevEv;
    fatal = r.elecLatch | elecError;
    redAlarm = magneticPickupFault | interpFault | flowOverload;
    if (fatal) begin
      modeNow = FPSI_FATAL;
    end else if (configMissing) begin
      modeNow = FPSI_CONFIG;
    end else if (!validCode) begin
      modeNow = FPSI_NOFACTOR;
    end else begin
      modeNow = FPSI_RUN;
    end
  end

  // Gray phase: B leads A going forward
  assign qA = qPhase[1];
  assign qB = qPhase[1] ^ qPhase[0];

  // APB read mux and decode
  always_comb begin
    mapped = 1'b1;
    rdMux = '0;
    case (paddr)
      REG_STATUS: rdMux[EV_W-1:0] = {configMissing, fatal, flowOverload, interpFault, magneticPickupFault};
      REG_INT_STATUS: rdMux[EV_W-1:0] = r.intStat;
      REG_INT_MASK: rdMux[EV_W-1:0] = r.intMask;
      REG_STATE: begin
        rdMux[ST_YELLOW:ST_RED] = r.lamps;
        rdMux[ST_CODE_LSB+:4] = factorSelectorSwitch;
        rdMux[ST_PHASE_LSB+:2] = qPhase;
        rdMux[ST_DIR] = qDirPos;
        rdMux[ST_MODE_LSB+:2] = r.mode;
      end
      default: mapped = 1'b0;
    endcase
  end

  assign pready = ce & r.rdReady;
  assign xferDone = psel & penable & pready;

  // Next state of the whole block
  always_comb begin
    n = r;
    n.mode = modeNow;
    n.rev = directionReverseSwitch;
    n.prevEv = ev;
    n.elecLatch = fatal;
    // Lamps, yellow-green-red
    case (modeNow)
      FPSI_FATAL: n.lamps = {3{flashLit}};
      FPSI_CONFIG: n.lamps = 3'h7;
      FPSI_NOFACTOR: n.lamps = {1'b0, flashLit, redAlarm};
      FPSI_RUN: n.lamps = {1'b0, 1'b1, redAlarm};
      default: n.lamps = 3'h7;
    endcase
    // Pins float on errors that inhibit output
    n.pinOe = (modeNow == FPSI_RUN) || (modeNow == FPSI_NOFACTOR);
    if (modeNow == FPSI_RUN) begin
      n.chanA = directionReverseSwitch ? qB : qA;
      n.chanB = directionReverseSwitch ? qA : qB;
      n.dirOut = qDirPos ^ directionReverseSwitch;
    end else begin
      n.chanA = 1'b0;
      n.chanB = 1'b0;
      n.dirOut = 1'b0;
    end
    // Capture read data once per transfer
    if (psel && !r.rdReady) begin
      n.prdata = rdMux;
      n.pslverr = ~mapped;
    end
    n.rdReady = psel & ~(penable & r.rdReady);
    // Sticky status: clear by one, a new event wins
    if (xferDone && pwrite && mapped && paddr == REG_INT_STATUS) begin
      n.intStat = r.intStat & ~pwdata[EV_W-1:0];
    end
    if (xferDone && pwrite && mapped && paddr == REG_INT_MASK) begin
      n.intMask = pwdata[EV_W-1:0];
    end
    n.intStat = n.intStat | rise;
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.intMask <= INT_MASK_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  // Outputs
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign chanAOut = r.chanA;
  assign chanBOut = r.chanB;
  assign directionOutput = r.dirOut;
  assign chanAOe = r.pinOe;
  assign chanBOe = r.pinOe;
  assign directionOutputOe = r.pinOe;
  assign lampYellow = r.lamps[ST_YELLOW];
  assign lampGreen = r.lamps[ST_GREEN];
  assign lampRed = r.lamps[ST_RED];
  assign irq = |(r.intStat & r.intMask);

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  logic steadyRun;
  assign steadyRun = ce && modeNow == FPSI_RUN && r.mode == FPSI_RUN && directionReverseSwitch == r.rev;

  sequence s_normal;
    ce && !fatal && !configMissing && validCode && !redAlarm;
  endsequence

  sequence s_fatalSeen;
    ce && elecError;
  endsequence

  property p_normalLamps;
    s_normal |=> lampGreen && !lampYellow && !lampRed;
  endproperty
  a_normalLamps: assert property (p_normalLamps) else $error("normal lamps wrong");

  property p_noFactor;
    ce && !fatal && !configMissing && !validCode |=> !chanAOut && !chanBOut && chanAOe && !lampYellow;
  endproperty
  a_noFactor: assert property (p_noFactor) else $error("no factor outputs wrong");

  property p_redAlarm;
    ce && !fatal && !configMissing && redAlarm |=> lampRed;
  endproperty
  a_redAlarm: assert property (p_redAlarm) else $error("red lamp missing on fault");

  property p_config;
    ce && !fatal && configMissing |=> lampYellow && lampGreen && lampRed && !chanAOe && !directionOutputOe;
  endproperty
  a_config: assert property (p_config) else $error("config state wrong");

  property p_fatalSticky;
    s_fatalSeen ##1 (ce [*2]) |=> !chanAOe && !chanBOe && !directionOutputOe && lampRed == lampGreen;
  endproperty
  a_fatalSticky: assert property (p_fatalSticky) else $error("electronics error not held");

  property p_float;
    ce && fatal |=> !chanAOe && !chanBOe && !directionOutputOe;
  endproperty
  a_float: assert property (p_float) else $error("pins driven during fatal error");

  property p_quadGray;
    steadyRun |=> !(chanAOut != $past(chanAOut) && chanBOut != $past(chanBOut));
  endproperty
  a_quadGray: assert property (p_quadGray) else $error("both channels moved together");

  property p_badCode;
    factorSelectorSwitch >= FIRST_BAD_CODE |-> !validCode && modeNow != FPSI_RUN;
  endproperty
  a_badCode: assert property (p_badCode) else $error("invalid code accepted");

  property p_eventIrq;
    ce [*2] ##0 (rise[EV_OVERLOAD] && r.intMask[EV_OVERLOAD]) |=> irq && r.intStat[EV_OVERLOAD];
  endproperty
  a_eventIrq: assert property (p_eventIrq) else $error("event did not raise interrupt");

  property p_apbZeroWait;
    ce && psel && !penable && !r.rdReady ##1 ce && psel && penable |-> pready;
  endproperty
  a_apbZeroWait: assert property (p_apbZeroWait) else $error("bus answer late");
endmodule

/* dv/fpsi_eval_model.sv */
// Evaluating counter model: decodes the quadrature pins into a signed position.
// Assumes pins are sampled on mclk; floated pins are not counted.
module fpsi_eval_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Quadrature pins
  input wire logic chanA,
  input wire logic chanAOe,
  input wire logic chanB,
  input wire logic chanBOe,
  // Decoded result
  output int position,
  output int jumps
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] prevIdx;
  logic [1:0] idx;
  logic [1:0] delta;
  // Gray index of the pin pair, B leads A in forward flow
  assign idx = {chanA, chanA ^ chanB};
  assign delta = idx - prevIdx;
  // Count quarter steps; a two-quarter jump means the channels lost their spacing
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      position <= 0;
      jumps <= 0;
      prevIdx <= 2'h0;
    end else begin
      if (chanAOe && chanBOe && delta == 2'h1) begin
        position <= position + 1;
      end else if (chanAOe && chanBOe && delta == 2'h3) begin
        position <= position - 1;
      end else if (chanAOe && chanBOe && delta == 2'h2) begin
        jumps <= jumps + 1;
      end
      prevIdx <= idx;
    end
  end
endmodule

/* dv/testbench.sv */
// Self-checking bench of the flow pulse and status indicator.
// Assumes fpsi_eval_model as the counting device on the pins.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fpsi_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] alarm = 3'h0;
  logic elecF = 1'b0;
  logic cfgF = 1'b0;
  logic stepUp = 1'b0;
  logic stepDown = 1'b0;
  logic revSw = 1'b0;
  logic [3:0] codeSw = 4'h0;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready, pslverr, rerr, aOut, aOe, bOut, bOe, dOut, dOe, lampY, lampG, lampR, irq;
  int mismatches = 0;
  int comparisons = 0;
  int pos, jumps, n, nj, ny, ng, nr;
  int facTab[11] = '{1, 2, 3, 4, 5, 8, 10, 12, 16, 24, 32};

  // Clock of 5 ns
  always #2.5 mclk = ~mclk;

  fpsi_indicator #(.FLASH_HALF(8)) i_dut (.mclk(mclk), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .magneticPickupFault(alarm[0]), .interpFault(alarm[1]),
    .flowOverload(alarm[2]), .elecError(elecF), .configMissing(cfgF), .stepUp(stepUp),
    .stepDown(stepDown), .factorSelectorSwitch(codeSw), .directionReverseSwitch(revSw),
    .chanAOut(aOut), .chanAOe(aOe), .chanBOut(bOut), .chanBOe(bOe), .directionOutput(dOut),
    .directionOutputOe(dOe), .lampYellow(lampY), .lampGreen(lampG), .lampRed(lampR), .irq(irq));

  fpsi_eval_model i_eval (.mclk(mclk), .rst(rst), .chanA(aOut), .chanAOe(aOe), .chanB(bOut),
    .chanBOe(bOe), .position(pos), .jumps(jumps));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer, held until pready is seen at a falling edge
  task automatic apb(logic wr, logic [7:0] addr, logic [31:0] wd);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(negedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      mismatches++;
      complete_run();
    end
    @(posedge mclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_cyc(int k);
    repeat (k) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Fine step pulses, one every second cycle
  task automatic steps(logic up, int k);
    repeat (k) begin
      @(posedge mclk);
      stepUp <= up;
      stepDown <= !up;
      @(posedge mclk);
      stepUp <= 1'b0;
      stepDown <= 1'b0;
    end
    wait_cyc(4);
  endtask

  // Lit cycles of each lamp over one full flash period
  task automatic flash_cnt();
    ny = 0;
    ng = 0;
    nr = 0;
    repeat (16) begin
      @(negedge mclk);
      ny += int'(lampY);
      ng += int'(lampG);
      nr += int'(lampR);
    end
  endtask

  task automatic lamps(logic [2:0] ygr, logic oe);
    chk("lamps and enables", {lampY, lampG, lampR, aOe, bOe, dOe}, {ygr, oe, oe, oe});
  endtask

  // Main sequence
  initial begin
    wait_cyc(2);
    chk("reset outputs", {lampY, lampG, lampR, aOe, bOe, dOe, irq, pready}, 8'h00);
    @(posedge mclk);
    rst <= 1'b0;
    wait_cyc(3);
    lamps(3'b010, 1'b1);
    chk("direction pin", dOut, 1'b1);
    $display("Test reset done");
    // Every selector code, changed while running
    for (int c = 0; c < 16; c++) begin
      @(posedge mclk);
      codeSw <= 4'(c);
      wait_cyc(3);
      n = pos;
      nj = jumps;
      if (c >= 11) begin
        flash_cnt();
        chk("no factor flash", {8'(ny), 8'(ng), 8'(nr)}, 24'h000800);
        chk("no factor pins", {aOut, bOut, dOut, aOe, bOe, dOe}, 6'h07);
      end
      steps(1'b1, 32);
      chk("quarters per 32 steps", 32'(pos - n), c < 11 ? facTab[c] : 0);
      chk("quadrature jumps", 32'(jumps - nj), 32'h0);
    end
    $display("Test factors done");
    @(posedge mclk);
    codeSw <= 4'hA;
    wait_cyc(3);
    n = pos;
    steps(1'b0, 4);
    chk("reverse flow", 32'(pos - n), -4);
    chk("direction negative", dOut, 1'b0);
    @(posedge mclk);
    revSw <= 1'b1;
    wait_cyc(3);
    n = pos;
    steps(1'b1, 4);
    chk("swapped channels", 32'(pos - n), -4);
    chk("inverted direction", dOut, 1'b0);
    steps(1'b0, 2);
    chk("inverted direction back", dOut, 1'b1);
    @(posedge mclk);
    revSw <= 1'b0;
    $display("Test direction done");
    apb(1'b1, REG_INT_MASK, 32'h1F);
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      alarm <= 3'(1 << k);
      wait_cyc(3);
      lamps(3'b011, 1'b1);
      n = pos;
      steps(1'b1, 2);
      chk("pulses during alarm", 32'(pos - n), 32'h2);
      chk("irq raised", irq, 1'b1);
      apb(1'b0, REG_INT_STATUS, 32'h0);
      chk("sticky status", rdata, 32'(1 << k));
      @(posedge mclk);
      alarm <= 3'h0;
      apb(1'b1, REG_INT_STATUS, 32'(1 << k));
      wait_cyc(2);
      chk("irq cleared", irq, 1'b0);
      lamps(3'b010, 1'b1);
    end
    apb(1'b1, REG_INT_MASK, 32'h0);
    @(posedge mclk);
    alarm <= 3'h4;
    wait_cyc(3);
    chk("masked irq", irq, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", rerr, 32'h1);
    chk("unmapped read", rdata, 32'h0);
    $display("Test alarms done");
    @(posedge mclk);
    cfgF <= 1'b1;
    wait_cyc(3);
    lamps(3'b111, 1'b0);
    // State word: lamps 111, code A, phase 1, last move forward, mode config
    apb(1'b0, REG_STATE, 32'h0);
    chk("state register", rdata, 32'h000025A7);
    // Live status: configuration needed and overload still high
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status register", rdata, 32'h00000014);
    n = pos;
    steps(1'b1, 8);
    chk("no pulses in config", 32'(pos - n), 32'h0);
    $display("Test config done");
    @(posedge mclk);
    elecF <= 1'b1;
    @(posedge mclk);
    elecF <= 1'b0;
    wait_cyc(3);
    flash_cnt();
    chk("fatal flash", {8'(ny), 8'(ng), 8'(nr)}, 24'h080808);
    chk("fatal float", {aOe, bOe, dOe}, 3'h0);
    // Sticky bits: overload, electronics error and configuration, all masked
    apb(1'b0, REG_INT_STATUS, 32'h0);
    chk("sticky after fatal", rdata, 32'h0000001C);
    chk("masked irq after fatal", irq, 1'b0);
    @(posedge mclk);
    cfgF <= 1'b0;
    alarm <= 3'h0;
    wait_cyc(3);
    flash_cnt();
    chk("fatal stays", {8'(ny), 8'(ng), 8'(nr)}, 24'h080808);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("fatal status latched", rdata, 32'h00000008);
    $display("Test fatal done");
    complete_run();
  end
endmodule
